// [tb/kwdtp_checker.sv]
// port checker of the keyed watchdog pair
`timescale 1ns/100ps
`default_nettype none

module kwdtp_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire kwdtp_pkg::kwdtp_req_t reg_req,
   input wire logic [31:0] reg_rdata_ff,
   input wire logic reg_rvalid_ff,
   // expiry
   input wire logic [kwdtp_pkg::NUM_TIMERS-1:0] wdt_expired
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   a_read_answer:
   assert property (reg_req.rd |=> reg_rvalid_ff)
      else $error("read not answered");
   a_no_spurious:
   assert property (!reg_req.rd |=> !reg_rvalid_ff)
      else $error("answer without read");
   a_rdata_hold:
   assert property (!reg_req.rd |=> $stable(reg_rdata_ff))
      else $error("read data moved without read");
   a_stat_upper:
   assert property (reg_req.rd && reg_req.sel_stat
      |=> reg_rdata_ff[31:16] == 16'h0000)
      else $error("status upper half not zero");
   a_ctrl_fields:
   assert property (reg_req.rd && !reg_req.sel_stat
      |=> reg_rdata_ff[31:24] == 8'h00 && reg_rdata_ff[21:20] == 2'b00)
      else $error("control reserved bits set");
   a_reset_clear:
   assert property ($fell(srst) |-> wdt_expired == 2'b00 && !reg_rvalid_ff)
      else $error("outputs not cleared by reset");
   a_expiry_sticky:
   assert property (!reg_req.wr
      |=> (wdt_expired & $past(wdt_expired)) == $past(wdt_expired))
      else $error("expiry dropped without write");
   a_stat_zero:
   assert property (reg_req.rd && reg_req.sel_stat && !reg_req.wr
      && wdt_expired[reg_req.sel_timer] |=> reg_rdata_ff[15:0] == 16'h0000)
      else $error("expired timer count not zero");
   a_stat_live:
   assert property (reg_req.rd && reg_req.sel_stat && !reg_req.wr
      && !wdt_expired[reg_req.sel_timer] |=> reg_rdata_ff[15:0] != 16'h0000)
      else $error("zero count without expiry");
endmodule

bind kwdtp_top kwdtp_checker u_chk (.core_clk(core_clk), .srst(srst),
   .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
   .reg_rvalid_ff(reg_rvalid_ff), .wdt_expired(wdt_expired));
`default_nettype wire

// [tb/tb_keyed_watchdog_timer_pair.sv]
// self-checking bench of the keyed watchdog pair
`timescale 1ns/100ps
`default_nettype none

module tb_keyed_watchdog_timer_pair;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   kwdtp_pkg::kwdtp_req_t reg_req = '0;
   logic [31:0] reg_rdata_ff;
   logic reg_rvalid_ff;
   logic [1:0] wdt_expired;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int seed = 32'hB807B983;
   logic [31:0] rnd;
   // model: stored fields, arm state and loaded count per timer
   logic run[2] = '{1'b1, 1'b1};
   logic armed[2] = '{1'b0, 1'b0};
   logic [3:0] res[2] = '{4'h9, 4'h9};
   logic [15:0] rld[2] = '{16'h3D09, 16'h7A12};
   logic [15:0] cnt[2] = '{16'h3D09, 16'h7A12};

   kwdtp_top #(.US_DIV(10)) u_dut (.core_clk(core_clk), .srst(srst),
      .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff), .wdt_expired(wdt_expired));

   // ---------------------------------------------------------------
   // clock, timeout and report
   // ---------------------------------------------------------------
   always #50 core_clk = ~core_clk;

   // longest expiry wait is well under this ceiling
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // bus tasks and model
   // ---------------------------------------------------------------
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] cw(logic t);
      return {8'h00, run[t], armed[t], 2'b00, res[t], rld[t]};
   endfunction

   // any write while armed disarms; only a keyed commit loads
   task automatic wr(logic t, logic [3:0] be, logic [31:0] d);
      @(posedge core_clk);
      reg_req <= '{1'b1, 1'b0, t, 1'b0, be, d};
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
      if (!armed[t]) begin
         armed[t] = be == 4'h8 && d[31:24] == 8'h55;
      end else begin
         armed[t] = 1'b0;
         if (be[3] && d[31:24] == 8'hAA) begin
            if (be[2]) begin
               run[t] = d[23];
               res[t] = d[19:16];
               if (be[1] && be[0]) rld[t] = d[15:0];
            end
            cnt[t] = rld[t];
         end
      end
   endtask

   task automatic prog(logic t, logic [3:0] be, logic [31:0] d);
      wr(t, 4'h8, 32'h5500_0000);
      wr(t, be, d);
   endtask

   task automatic rd(logic t, logic s, logic [31:0] e);
      @(posedge core_clk);
      reg_req <= '{1'b0, 1'b1, t, s, 4'h0, 32'h0};
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1;
      chk({31'h0, reg_rvalid_ff}, 32'h1);
      chk(reg_rdata_ff, e);
   endtask

   // tick phase gives up to one microsecond of slack
   task automatic expire(logic t);
      int k;
      int n;
      #1;
      n = cnt[t] * (1 << res[t]) * 10;
      k = 0;
      while (wdt_expired[t] !== 1'b1 && k < 2000) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk({31'h0, k >= n - 11 && k <= n + 3}, 32'h1);
      cnt[t] = 16'h0000;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      for (int t = 0; t < 2; t++) begin
         rd(t, 0, cw(t));
         rd(t, 1, {16'h0, cnt[t]});
      end
      wr(0, 4'hC, 32'h5500_0000);
      rd(0, 0, cw(0));
      wr(0, 4'h8, 32'h5A00_0000);
      rd(0, 0, cw(0));
      wr(0, 4'h8, 32'h5500_0000);
      rd(0, 0, cw(0));
      rd(0, 0, cw(0));
      rd(0, 1, {16'h0, cnt[0]});
      wr(0, 4'h7, 32'hAA00_0001);
      rd(0, 0, cw(0));
      for (int i = 0; i < 3; i++) begin
         rnd = $random(seed);
         // commit key with run set, random res 0..3, reload 2..9
         prog(0, 4'hF, {14'h2AA0, rnd[1:0], 13'h0, rnd[4:2]} + 32'h2);
         expire(0);
         rd(0, 0, cw(0));
         rd(0, 1, 32'h0);
         repeat (30) @(posedge core_clk);
         chk({31'h0, wdt_expired[0]}, 32'h1);
      end
      // slowest resolution first, so the reload read after is exact
      prog(0, 4'hC, 32'hAA8F_1234);
      rd(0, 0, cw(0));
      rd(0, 1, {16'h0, cnt[0]});
      prog(0, 4'h8, 32'hAA00_0000);
      rd(0, 1, {16'h0, cnt[0]});
      chk({31'h0, wdt_expired[0]}, 32'h0);
      rd(0, 0, cw(0));
      prog(0, 4'hF, 32'hAA00_0002);
      repeat (100) @(posedge core_clk);
      rd(0, 1, 32'h0000_0002);
      chk({31'h0, wdt_expired[0]}, 32'h0);
      rd(1, 0, cw(1));
      chk({31'h0, wdt_expired[1]}, 32'h0);
      // mid-run reset with the second timer armed
      wr(1, 4'h8, 32'h5500_0000);
      rd(1, 0, cw(1));
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      run = '{1'b1, 1'b1};
      armed = '{1'b0, 1'b0};
      res = '{4'h9, 4'h9};
      rld = '{16'h3D09, 16'h7A12};
      cnt = rld;
      rd(1, 0, cw(1));
      rd(0, 0, cw(0));
      rd(0, 1, {16'h0, cnt[0]});
      chk({30'h0, wdt_expired}, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire

// [verilog/kwdtp_pkg.sv]
// constants, field layouts and carrier types of the keyed watchdog pair

package kwdtp_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int US_PER_S = 1000000;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int COUNT_W = 16;
   localparam int RES_W = 4;
   localparam int PRE_W = 15;
   localparam int NUM_TIMERS = 2;

   // ------------------------------------------------------------------
   // control register layout (lane 3 holds the key)
   // ------------------------------------------------------------------
   localparam int KEY_LSB = 24;
   localparam int RUN_BIT = 23;
   localparam int ARM_BIT = 22;
   localparam int RES_LSB = 16;
   localparam int RELOAD_LSB = 0;
   localparam int BE_KEY = 3;
   localparam int BE_CFG = 2;
   localparam int BE_RLD_HI = 1;
   localparam int BE_RLD_LO = 0;
   localparam logic [3:0] BE_KEY_ONLY = 4'h8;
   localparam logic [7:0] KEY_ARM = 8'h55;
   localparam logic [7:0] KEY_COMMIT = 8'hAA;

   // register select within one timer
   localparam logic REG_CTRL = 1'b0;
   localparam logic REG_STAT = 1'b1;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic RST_RUN = 1'b1;
   localparam logic [RES_W-1:0] RST_RES = 4'h9;
   localparam int RST_TIME0_S = 8;
   localparam int RST_TIME1_S = 16;
   localparam logic [COUNT_W-1:0] RST_RELOAD0 =
      COUNT_W'((RST_TIME0_S * US_PER_S) >> RST_RES);
   localparam logic [COUNT_W-1:0] RST_RELOAD1 =
      COUNT_W'((RST_TIME1_S * US_PER_S) >> RST_RES);

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic sel_timer;
      logic sel_stat;
      logic [3:0] be;
      logic [31:0] wdata;
   } kwdtp_req_t;

   typedef struct packed {
      logic run;
      logic [RES_W-1:0] res;
      logic [COUNT_W-1:0] count;
   } kwdtp_load_t;

   typedef enum logic {
      KWDTP_UNARMED = 1'b0,
      KWDTP_ARMED = 1'b1
   } kwdtp_arm_t;

endpackage

// [verilog/kwdtp_timer.sv]
// one watchdog: power-of-two prescaler and down-counter
`timescale 1ns/100ps
`default_nettype none

module kwdtp_timer #(
   parameter logic RST_RUN = kwdtp_pkg::RST_RUN,
   parameter logic [kwdtp_pkg::RES_W-1:0] RST_RES = kwdtp_pkg::RST_RES,
   parameter logic [kwdtp_pkg::COUNT_W-1:0] RST_COUNT =
      kwdtp_pkg::RST_RELOAD0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // base tick
   input wire logic us_tick,
   // load strobe with its values
   input wire logic load,
   input wire kwdtp_pkg::kwdtp_load_t load_val,
   // state
   output logic [kwdtp_pkg::COUNT_W-1:0] count_ff,
   output logic expired_ff
);

   logic run_ff;
   logic [kwdtp_pkg::RES_W-1:0] res_ff;
   logic [kwdtp_pkg::PRE_W-1:0] pre_ff;
   logic [kwdtp_pkg::COUNT_W-1:0] nxt_count;

   // period mask is two to the resolution, minus one
   wire [kwdtp_pkg::PRE_W-1:0] pre_last =
      kwdtp_pkg::PRE_W'((32'h1 << res_ff) - 32'h1);
   wire pre_done = (pre_ff == pre_last);
   wire at_zero = (count_ff == '0);
   // one count per full prescaler period
   wire dec = run_ff && us_tick && pre_done && !at_zero;

   // decrement unless loading; hold at zero
   assign nxt_count = load ? load_val.count :
                      dec ? count_ff - 16'h0001 : count_ff;

   // prescaler restarts on load so the first period is whole
   always_ff @(posedge core_clk) begin
      if (srst) begin
         run_ff <= RST_RUN;
         res_ff <= RST_RES;
         pre_ff <= '0;
      end else if (load) begin
         run_ff <= load_val.run;
         res_ff <= load_val.res;
         pre_ff <= '0;
      end else if (run_ff && us_tick) begin
         pre_ff <= pre_done ? '0 : pre_ff + 15'h0001;
      end
   end

   // expiry flag follows the zero count
   always_ff @(posedge core_clk) begin
      if (srst) begin
         count_ff <= RST_COUNT;
         expired_ff <= (RST_COUNT == '0);
      end else begin
         count_ff <= nxt_count;
         expired_ff <= (nxt_count == '0);
      end
   end

endmodule
`default_nettype wire

// [verilog/kwdtp_top.sv]
// keyed watchdog timer pair: register port, arm/commit logic, two timers
`timescale 1ns/100ps
`default_nettype none

module kwdtp_top #(
   parameter int US_DIV = kwdtp_pkg::US_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register access port
   input wire kwdtp_pkg::kwdtp_req_t reg_req,
   output logic [31:0] reg_rdata_ff,
   output logic reg_rvalid_ff,
   // timer expiry outputs
   output logic [kwdtp_pkg::NUM_TIMERS-1:0] wdt_expired
);

   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   if (US_DIV < 2) begin : g_bad_div
      $error("microsecond divider must be at least 2");
   end

   localparam int NT = kwdtp_pkg::NUM_TIMERS;
   localparam int CW = kwdtp_pkg::COUNT_W;
   localparam int RW = kwdtp_pkg::RES_W;

   // ------------------------------------------------------------------
   // stored control fields, one set per timer
   // ------------------------------------------------------------------
   logic [NT-1:0] ctl_run_ff;
   logic [RW-1:0] ctl_res_ff [NT];
   logic [CW-1:0] ctl_reload_ff [NT];
   kwdtp_pkg::kwdtp_arm_t arm_ff [NT];
   logic [CW-1:0] cnt [NT];
   logic [NT-1:0] exp_ff;
   logic us_tick;

   // ------------------------------------------------------------------
   // write decode shared by both timers
   // ------------------------------------------------------------------
   wire [7:0] wr_key = reg_req.wdata[kwdtp_pkg::KEY_LSB +: 8];
   wire wr_run = reg_req.wdata[kwdtp_pkg::RUN_BIT];
   wire [RW-1:0] wr_res = reg_req.wdata[kwdtp_pkg::RES_LSB +: RW];
   wire [CW-1:0] wr_reload = reg_req.wdata[kwdtp_pkg::RELOAD_LSB +: CW];
   wire ctl_wr = reg_req.wr && (reg_req.sel_stat == kwdtp_pkg::REG_CTRL);

   // arm needs the arm key with only the key lane
   wire arm_ok = (reg_req.be == kwdtp_pkg::BE_KEY_ONLY) &&
                 (wr_key == kwdtp_pkg::KEY_ARM);
   // commit needs the key lane carrying the commit key
   wire commit_ok = reg_req.be[kwdtp_pkg::BE_KEY] &&
                    (wr_key == kwdtp_pkg::KEY_COMMIT);
   wire cfg_lane = reg_req.be[kwdtp_pkg::BE_CFG];
   wire rld_lanes = reg_req.be[kwdtp_pkg::BE_RLD_HI] &&
                    reg_req.be[kwdtp_pkg::BE_RLD_LO];

   // ------------------------------------------------------------------
   // base tick
   // ------------------------------------------------------------------
   kwdtp_us_tick #(
      .DIV(US_DIV)
   ) u_tick (
      .core_clk(core_clk),
      .srst(srst),
      .us_tick_ff(us_tick)
   );

   // ------------------------------------------------------------------
   // per-timer control logic and timer instance
   // ------------------------------------------------------------------
   // two independent timers
   for (genvar t = 0; t < NT; t++) begin : g_tmr
      // reset timeouts of 8 s and 16 s
      localparam logic [CW-1:0] RST_RLD =
         (t == 0) ? kwdtp_pkg::RST_RELOAD0 : kwdtp_pkg::RST_RELOAD1;

      wire hit = ctl_wr && (reg_req.sel_timer == 1'(t));
      wire armed = (arm_ff[t] == kwdtp_pkg::KWDTP_ARMED);
      wire commit = hit && armed && commit_ok;
      wire take_cfg = commit && cfg_lane;
      wire take_rld = take_cfg && rld_lanes;
      kwdtp_pkg::kwdtp_load_t lv;

      // stored fields, data config with old reload
      assign lv.run = take_cfg ? wr_run : ctl_run_ff[t];
      assign lv.res = take_cfg ? wr_res : ctl_res_ff[t];
      assign lv.count = take_rld ? wr_reload : ctl_reload_ff[t];

      // arm state: unarmed, armed by key, dropped by any second write
      always_ff @(posedge core_clk) begin
         if (srst) begin
            arm_ff[t] <= kwdtp_pkg::KWDTP_UNARMED;
         end else if (hit) begin
            case (arm_ff[t])
               // arming write leaves the timer alone
               kwdtp_pkg::KWDTP_UNARMED: begin
                  arm_ff[t] <= arm_ok ? kwdtp_pkg::KWDTP_ARMED :
                                        kwdtp_pkg::KWDTP_UNARMED;
               end
               default: begin
                  arm_ff[t] <= kwdtp_pkg::KWDTP_UNARMED;
               end
            endcase
         end
      end

      // stored field and reload updates on commit
      always_ff @(posedge core_clk) begin
         if (srst) begin
            ctl_run_ff[t] <= kwdtp_pkg::RST_RUN;
            ctl_res_ff[t] <= kwdtp_pkg::RST_RES;
            ctl_reload_ff[t] <= RST_RLD;
         end else begin
            if (take_cfg) begin
               ctl_run_ff[t] <= wr_run;
               ctl_res_ff[t] <= wr_res;
            end
            // reload taken only with all lanes
            if (take_rld) begin
               ctl_reload_ff[t] <= wr_reload;
            end
         end
      end

      kwdtp_timer #(
         .RST_RUN(kwdtp_pkg::RST_RUN),
         .RST_RES(kwdtp_pkg::RST_RES),
         .RST_COUNT(RST_RLD)
      ) u_timer (
         .core_clk(core_clk),
         .srst(srst),
         .us_tick(us_tick),
         .load(commit),
         .load_val(lv),
         .count_ff(cnt[t]),
         .expired_ff(exp_ff[t])
      );
   end

   assign wdt_expired = exp_ff;

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   // read data registered, one cycle after the strobe
   wire rsel = reg_req.sel_timer;
   wire [31:0] ctl_word = {8'h00,
                           ctl_run_ff[rsel],
                           (arm_ff[rsel] == kwdtp_pkg::KWDTP_ARMED),
                           2'b00,
                           ctl_res_ff[rsel],
                           ctl_reload_ff[rsel]};
   wire [31:0] stat_word = {16'h0000, cnt[rsel]};
   wire [31:0] rd_word = (reg_req.sel_stat == kwdtp_pkg::REG_STAT) ?
                         stat_word : ctl_word;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata_ff <= 32'h00000000;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= reg_req.rd;
         if (reg_req.rd) begin
            reg_rdata_ff <= rd_word;
         end
      end
   end

endmodule
`default_nettype wire

// [verilog/kwdtp_us_tick.sv]
// fixed divider making the one-microsecond base tick
`timescale 1ns/100ps
`default_nettype none

module kwdtp_us_tick #(
   parameter int DIV = kwdtp_pkg::US_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // base tick, one cycle every DIV clocks
   output logic us_tick_ff
);

   // elaboration check: the 16-bit counter bounds the divider from above
   if (DIV < 2 || DIV > 65536) begin : g_bad_div
      $error("divider must be 2 to 65536");
   end

   logic [15:0] div_ff;
   wire div_end = (div_ff == 16'(DIV - 1));

   always_ff @(posedge core_clk) begin
      if (srst) begin
         div_ff <= 16'h0000;
         us_tick_ff <= 1'b0;
      end else begin
         div_ff <= div_end ? 16'h0000 : div_ff + 16'h0001;
         us_tick_ff <= div_end;
      end
   end

endmodule
`default_nettype wire
